// *** inc/ioc_pkg.sv ***
// Shared constants and types for the I/O channel block-transfer section
package ioc_pkg;
  // ==========================================================
  // Word and storage geometry
  localparam int unsigned IOC_N_CHAN = 14;
  localparam int unsigned IOC_WORD_W = 30;
  localparam int unsigned IOC_HALF_W = 15;
  localparam int unsigned IOC_ADDR_W = 15;
  localparam int unsigned IOC_MEM_DEPTH = 32768;
  localparam int unsigned IOC_CHAN_W = 4;
  localparam int unsigned IOC_PEER_CHANS = 2;
  localparam int unsigned IOC_DRV_GROUPS = 3;
  localparam int unsigned IOC_CHANS_PER_GROUP = 4;

  // ==========================================================
  // Storage cycle timing
  localparam int unsigned IOC_CLK_PERIOD_NS = 20;
  localparam int unsigned IOC_MEM_CYCLE_NS = 8000;
  localparam int unsigned IOC_CYCLE_CLKS = IOC_MEM_CYCLE_NS / IOC_CLK_PERIOD_NS;
  localparam int unsigned IOC_HALF_CLKS = IOC_CYCLE_CLKS / 2;
  localparam int unsigned IOC_CNT_W = $clog2(IOC_HALF_CLKS);
  localparam logic [IOC_CNT_W-1:0] IOC_PH_ISSUE = 8'h00;
  localparam logic [IOC_CNT_W-1:0] IOC_PH_CAPTURE = 8'h01;
  localparam logic [IOC_CNT_W-1:0] IOC_PH_LAST = 8'(IOC_HALF_CLKS - 1);

  // ==========================================================
  // Control word locations, one word per channel and direction
  localparam logic [IOC_ADDR_W-1:0] IOC_CW_IN_BASE = 15'h0020;
  localparam logic [IOC_ADDR_W-1:0] IOC_CW_OUT_BASE = 15'h0030;

  typedef enum logic [2:0] {
    IOC_IDLE,
    IOC_CW_RD,
    IOC_CW_RS,
    IOC_DW_RD,
    IOC_DW_RS
  } ioc_state_t;
endpackage : ioc_pkg

// *** inc/ioc_mem_if.sv ***
// Port bundle between the channel controller and core storage
`timescale 1ns/1ps
`default_nettype none
interface ioc_mem_if;
  logic en;
  logic we;
  logic [14:0] addr;
  logic [29:0] wdata;
  logic [29:0] rdata;
  modport ctl (output en, output we, output addr, output wdata, input rdata);
  modport mem (input en, input we, input addr, input wdata, output rdata);
endinterface : ioc_mem_if
`default_nettype wire

// *** src/ioc_core_mem.sv ***
// Core storage: 30-bit words, registered read data
`timescale 1ns/1ps
`default_nettype none
module ioc_core_mem import ioc_pkg::*; #(
  parameter int unsigned DEPTH = IOC_MEM_DEPTH
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  ioc_mem_if.mem bus
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [IOC_WORD_W-1:0] rdata;
  } ioc_mem_st_t;

  ioc_mem_st_t mem_reg;
  ioc_mem_st_t mem_next;
  logic [IOC_WORD_W-1:0] store [DEPTH];

  always_comb begin
    mem_next = mem_reg;
    if (bus.en && !bus.we) begin
      mem_next.rdata = store[bus.addr];
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mem_reg <= '0;
    end else begin
      mem_reg <= mem_next;
    end
  end

  // Array carries no reset, like the cores it stands for
  always_ff @(posedge sys_clk_in) begin
    if (bus.en && bus.we) begin
      store[bus.addr] <= bus.wdata;
    end
  end

  assign bus.rdata = mem_reg.rdata;
endmodule : ioc_core_mem
`default_nettype wire

// *** src/ioc_chan_top.sv ***
// I/O channel section: priority, control words and block transfers
// ==========================================================
// Function
// - Non-peer output words go through general register
// - General register drives three groups of four
// - Peer channels use separate peer output register
// - Output channels 0..13, highest served first
// - Fourteen gated 30-bit inputs, highest first
// - Channels 0 and 1 peer, lowest priority
// - Input words gated straight into storage
// - Request and acknowledge handshake per channel
// - Busy channels refuse a new start
// - One control word per channel gives addresses
// - Channel deactivates when count is reached
// - Destructive read then restore, eight microseconds
// - Restore adds one to a word half
// - Equal halves raise end of transfer
// - Transfer register split into two halves
// - Storage holds 32768 thirty-bit words
// - Fifteen-bit address register loaded each access
// - Either side may start a link
// - A channel running alone exceeds thirty thousand words/second
`timescale 1ns/1ps
`default_nettype none
module ioc_chan_top import ioc_pkg::*; #(
  parameter int unsigned N_CHAN = IOC_N_CHAN,
  parameter int unsigned W = IOC_WORD_W
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [N_CHAN-1:0] in_req_in,
  input wire logic [N_CHAN-1:0][W-1:0] in_data_in,
  output logic [N_CHAN-1:0] in_ack_out,
  input wire logic [N_CHAN-1:0] out_req_in,
  output logic [N_CHAN-1:0] out_ack_out,
  output logic [IOC_DRV_GROUPS-1:0][W-1:0] gen_drv_out,
  output logic [W-1:0] peer_out_out,
  input wire logic start_valid_in,
  input wire logic start_dir_in,
  input wire logic [IOC_CHAN_W-1:0] start_chan_in,
  output logic start_busy_out,
  output logic [N_CHAN-1:0] act_in_out,
  output logic [N_CHAN-1:0] act_out_out,
  output logic [N_CHAN-1:0] done_in_out,
  output logic [N_CHAN-1:0] done_out_out,
  input wire logic prog_valid_in,
  input wire logic prog_we_in,
  input wire logic [IOC_ADDR_W-1:0] prog_addr_in,
  input wire logic [W-1:0] prog_wdata_in,
  output logic prog_ready_out,
  output logic [W-1:0] prog_rdata_out
);
  // ==========================================================
  // State
  typedef struct packed {
    ioc_state_t st;
    logic [IOC_CNT_W-1:0] cnt;
    logic dir;
    logic [IOC_CHAN_W-1:0] chan;
    logic fin;
    logic [W-1:0] xfer;
    logic [IOC_ADDR_W-1:0] sar;
    logic [W-1:0] gen_out;
    logic [W-1:0] peer_out;
    logic [N_CHAN-1:0] act_in;
    logic [N_CHAN-1:0] act_out;
    logic [N_CHAN-1:0] arm_in;
    logic [N_CHAN-1:0] arm_out;
    logic [N_CHAN-1:0] ack_in;
    logic [N_CHAN-1:0] ack_out;
    logic [N_CHAN-1:0] done_in;
    logic [N_CHAN-1:0] done_out;
    logic [N_CHAN-1:0] rin_s1;
    logic [N_CHAN-1:0] rin_s2;
    logic [N_CHAN-1:0] rout_s1;
    logic [N_CHAN-1:0] rout_s2;
    logic [N_CHAN-1:0][W-1:0] din_s1;
    logic [N_CHAN-1:0][W-1:0] din_s2;
  } ioc_st_t;

  ioc_st_t st_reg;
  ioc_st_t st_next;

  ioc_mem_if mem_bus ();

  logic [N_CHAN-1:0] cand_in;
  logic [N_CHAN-1:0] cand_out;
  logic grant_in;
  logic grant_out;
  logic [IOC_CHAN_W-1:0] pick_in;
  logic [IOC_CHAN_W-1:0] pick_out;
  logic start_busy;
  logic [IOC_HALF_W-1:0] cur_next;

  // ==========================================================
  // Storage
  ioc_core_mem #(
    .DEPTH(IOC_MEM_DEPTH)
  ) u_mem (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .bus(mem_bus.mem)
  );

  // ==========================================================
  // Priority: an ascending scan lets the highest number win,
  // which also leaves the peer channels 0 and 1 last.
  always_comb begin
    cand_in = st_reg.act_in & st_reg.rin_s2 & st_reg.arm_in;
    cand_out = st_reg.act_out & st_reg.rout_s2 & st_reg.arm_out;
    grant_in = 1'b0;
    grant_out = 1'b0;
    pick_in = '0;
    pick_out = '0;
    for (int i = 0; i < N_CHAN; i++) begin
      if (cand_in[i]) begin
        grant_in = 1'b1;
        pick_in = IOC_CHAN_W'(i);
      end
      if (cand_out[i]) begin
        grant_out = 1'b1;
        pick_out = IOC_CHAN_W'(i);
      end
    end
  end

  // Out-of-range channel numbers report busy so they are refused
  always_comb begin
    if (start_chan_in >= IOC_CHAN_W'(N_CHAN)) begin
      start_busy = 1'b1;
    end else if (start_dir_in) begin
      start_busy = st_reg.act_out[start_chan_in];
    end else begin
      start_busy = st_reg.act_in[start_chan_in];
    end
  end

  assign cur_next = st_reg.xfer[W-1:IOC_HALF_W] + IOC_HALF_W'(1);

  // ==========================================================
  // Next state
  always_comb begin
    st_next = st_reg;
    mem_bus.en = 1'b0;
    mem_bus.we = 1'b0;
    mem_bus.addr = st_reg.sar;
    mem_bus.wdata = st_reg.xfer;
    // Request and data pins pass two flops before anything looks at them
    st_next.rin_s1 = in_req_in;
    st_next.rin_s2 = st_reg.rin_s1;
    st_next.rout_s1 = out_req_in;
    st_next.rout_s2 = st_reg.rout_s1;
    st_next.din_s1 = in_data_in;
    st_next.din_s2 = st_reg.din_s1;
    st_next.ack_in = '0;
    st_next.ack_out = '0;
    st_next.done_in = '0;
    st_next.done_out = '0;
    // A request is served once and rearms only after it drops
    st_next.arm_in = st_reg.arm_in | ~st_reg.rin_s2;
    st_next.arm_out = st_reg.arm_out | ~st_reg.rout_s2;

    if (start_valid_in && !start_busy) begin
      if (start_dir_in) begin
        st_next.act_out[start_chan_in] = 1'b1;
      end else begin
        st_next.act_in[start_chan_in] = 1'b1;
      end
    end

    case (st_reg.st)
      IOC_IDLE: begin
        st_next.cnt = '0;
        if (prog_valid_in) begin
          mem_bus.en = 1'b1;
          mem_bus.we = prog_we_in;
          mem_bus.addr = prog_addr_in;
          mem_bus.wdata = prog_wdata_in;
        end else if (grant_in || grant_out) begin
          // Input wins a tie with output: no buffer holds input data
          st_next.st = IOC_CW_RD;
          st_next.dir = !grant_in;
          st_next.chan = grant_in ? pick_in : pick_out;
          if (grant_in) begin
            st_next.sar = IOC_CW_IN_BASE + IOC_ADDR_W'(pick_in);
          end else begin
            st_next.sar = IOC_CW_OUT_BASE + IOC_ADDR_W'(pick_out);
          end
        end
      end

      IOC_CW_RD: begin
        st_next.cnt = st_reg.cnt + IOC_CNT_W'(1);
        if (st_reg.cnt == IOC_PH_ISSUE) begin
          mem_bus.en = 1'b1;
        end
        if (st_reg.cnt == IOC_PH_CAPTURE) begin
          st_next.xfer = mem_bus.rdata;
        end
        if (st_reg.cnt == IOC_PH_LAST) begin
          st_next.st = IOC_CW_RS;
          st_next.cnt = '0;
        end
      end

      IOC_CW_RS: begin
        st_next.cnt = st_reg.cnt + IOC_CNT_W'(1);
        if (st_reg.cnt == IOC_PH_ISSUE) begin
          mem_bus.en = 1'b1;
          mem_bus.we = 1'b1;
          mem_bus.wdata = {cur_next, st_reg.xfer[IOC_HALF_W-1:0]};
          st_next.xfer = {cur_next, st_reg.xfer[IOC_HALF_W-1:0]};
          st_next.sar = st_reg.xfer[W-1:IOC_HALF_W];
          st_next.fin = (cur_next == st_reg.xfer[IOC_HALF_W-1:0]);
        end
        if (st_reg.cnt == IOC_PH_LAST) begin
          st_next.st = IOC_DW_RD;
          st_next.cnt = '0;
        end
      end

      IOC_DW_RD: begin
        st_next.cnt = st_reg.cnt + IOC_CNT_W'(1);
        if (st_reg.cnt == IOC_PH_ISSUE) begin
          mem_bus.en = 1'b1;
        end
        if (st_reg.cnt == IOC_PH_CAPTURE) begin
          if (st_reg.dir) begin
            st_next.xfer = mem_bus.rdata;
            if (st_reg.chan < IOC_CHAN_W'(IOC_PEER_CHANS)) begin
              st_next.peer_out = mem_bus.rdata;
            end else begin
              st_next.gen_out = mem_bus.rdata;
            end
          end else begin
            // Read word is discarded; the channel's lines go to restore
            st_next.xfer = st_reg.din_s2[st_reg.chan];
          end
        end
        if (st_reg.cnt == IOC_PH_LAST) begin
          st_next.st = IOC_DW_RS;
          st_next.cnt = '0;
        end
      end

      IOC_DW_RS: begin
        st_next.cnt = st_reg.cnt + IOC_CNT_W'(1);
        if (st_reg.cnt == IOC_PH_ISSUE) begin
          mem_bus.en = 1'b1;
          mem_bus.we = 1'b1;
        end
        if (st_reg.cnt == IOC_PH_LAST) begin
          // Two storage cycles per word: under 62500 words/s, shared by all channels
          st_next.st = IOC_IDLE;
          st_next.cnt = '0;
          if (st_reg.dir) begin
            st_next.ack_out[st_reg.chan] = 1'b1;
            st_next.arm_out[st_reg.chan] = 1'b0;
            if (st_reg.fin) begin
              st_next.act_out[st_reg.chan] = 1'b0;
              st_next.done_out[st_reg.chan] = 1'b1;
            end
          end else begin
            st_next.ack_in[st_reg.chan] = 1'b1;
            st_next.arm_in[st_reg.chan] = 1'b0;
            if (st_reg.fin) begin
              st_next.act_in[st_reg.chan] = 1'b0;
              st_next.done_in[st_reg.chan] = 1'b1;
            end
          end
        end
      end

      default: begin
        st_next.st = IOC_IDLE;
        st_next.cnt = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Outputs
  always_comb begin
    for (int g = 0; g < IOC_DRV_GROUPS; g++) begin
      gen_drv_out[g] = st_reg.gen_out;
    end
  end

  assign peer_out_out = st_reg.peer_out;
  assign in_ack_out = st_reg.ack_in;
  assign out_ack_out = st_reg.ack_out;
  assign start_busy_out = start_busy;
  assign act_in_out = st_reg.act_in;
  assign act_out_out = st_reg.act_out;
  assign done_in_out = st_reg.done_in;
  assign done_out_out = st_reg.done_out;
  assign prog_ready_out = (st_reg.st == IOC_IDLE);
  assign prog_rdata_out = mem_bus.rdata;
endmodule : ioc_chan_top
`default_nettype wire

// *** bench/ioc_chan_asserts.sv ***
// Port-level assertions for the I/O channel section
`timescale 1ns/1ps
`default_nettype none
module ioc_chan_asserts import ioc_pkg::*; #(
  parameter int unsigned N_CHAN = IOC_N_CHAN,
  parameter int unsigned W = IOC_WORD_W
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [N_CHAN-1:0] in_ack_out,
  input wire logic [N_CHAN-1:0] out_ack_out,
  input wire logic [IOC_DRV_GROUPS-1:0][W-1:0] gen_drv_out,
  input wire logic [W-1:0] peer_out_out,
  input wire logic start_valid_in,
  input wire logic start_dir_in,
  input wire logic [IOC_CHAN_W-1:0] start_chan_in,
  input wire logic start_busy_out,
  input wire logic [N_CHAN-1:0] act_in_out,
  input wire logic [N_CHAN-1:0] act_out_out,
  input wire logic [N_CHAN-1:0] done_in_out,
  input wire logic [N_CHAN-1:0] done_out_out,
  input wire logic prog_ready_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  wire logic any_ack = |{in_ack_out, out_ack_out};
  wire logic [2*N_CHAN-1:0] act_all = {act_out_out, act_in_out};
  // ==========
  // Gap counter: starts saturated so the first acknowledge passes
  logic [10:0] gap_reg;
  logic [10:0] gap_next;
  always_comb begin
    gap_next = (gap_reg == 11'h7ff) ? gap_reg : gap_reg + 11'h001;
    if (any_ack) begin
      gap_next = 11'h000;
    end
  end
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gap_reg <= 11'h7ff;
    end else begin
      gap_reg <= gap_next;
    end
  end
  a_one_grant: assert property ($onehot0({in_ack_out, out_ack_out}))
    else $error("two acknowledges at once");
  a_storage_cycle: assert property (any_ack |-> gap_reg >= 11'h31f)
    else $error("acknowledges too close");
  a_store_busy: assert property (any_ack |-> !$past(prog_ready_out, 2))
    else $error("program port open during transfer");
  a_ack_active: assert property (any_ack |-> ({out_ack_out, in_ack_out} & ~$past(act_all)) == '0)
    else $error("acknowledge on idle channel");
  a_done_ack: assert property (({done_out_out, done_in_out} & ~{out_ack_out, in_ack_out}) == '0)
    else $error("done without acknowledge");
  a_done_deact: assert property (|{done_out_out, done_in_out} |-> ({done_out_out, done_in_out} & act_all) == '0)
    else $error("channel still active at done");
  a_start_take: assert property (start_valid_in && !start_busy_out |=> act_all[N_CHAN * $past(start_dir_in) + $past(start_chan_in)])
    else $error("start not taken");
  a_busy_range: assert property (start_chan_in >= N_CHAN |-> start_busy_out)
    else $error("missing channel not busy");
  a_busy_act: assert property (act_all[N_CHAN * start_dir_in + start_chan_in] |-> start_busy_out)
    else $error("active channel not busy");
  a_gen_fanout: assert property (gen_drv_out[0] == gen_drv_out[1] && gen_drv_out[1] == gen_drv_out[2])
    else $error("driver groups differ");
  a_gen_source: assert property (!$stable(gen_drv_out) |-> |act_out_out[N_CHAN-1:IOC_PEER_CHANS])
    else $error("general register moved without output");
  a_peer_source: assert property (!$stable(peer_out_out) |-> |act_out_out[IOC_PEER_CHANS-1:0])
    else $error("peer register moved without peer output");
endmodule : ioc_chan_asserts
bind ioc_chan_top ioc_chan_asserts #(.N_CHAN(N_CHAN), .W(W)) u_chk (
  .sys_clk_in, .rst_n_in, .in_ack_out, .out_ack_out, .gen_drv_out, .peer_out_out,
  .start_valid_in, .start_dir_in, .start_chan_in, .start_busy_out, .act_in_out,
  .act_out_out, .done_in_out, .done_out_out, .prog_ready_out
);
`default_nettype wire

// *** bench/ioc_periph.sv ***
// Behavioural peripherals on every input and output channel
`timescale 1ns/1ps
`default_nettype none
module ioc_periph import ioc_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic slow_in,
  input wire logic [IOC_WORD_W-1:0] rnd_in,
  input wire logic [2*IOC_N_CHAN-1:0] en_in,
  input wire logic [2*IOC_N_CHAN-1:0] ack_in,
  output logic [2*IOC_N_CHAN-1:0] req_out,
  output logic [IOC_N_CHAN-1:0][IOC_WORD_W-1:0] data_out
);
  // Bits 0..13 are input channels, 14..27 output channels
  int gap [2*IOC_N_CHAN];
  // Far side moves on the falling edge, half a cycle clear of the design's sampling edge
  always_ff @(negedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req_out <= '0;
      for (int i = 0; i < 2*IOC_N_CHAN; i++) gap[i] <= 4;
    end else begin
      for (int i = 0; i < 2*IOC_N_CHAN; i++) begin
        if (req_out[i] && ack_in[i]) begin
          req_out[i] <= 1'b0;
          // Low long enough to re-arm; slow mode lets others win
          gap[i] <= slow_in ? 20 : 2;
        end else if (!req_out[i] && gap[i] != 0) begin
          gap[i] <= gap[i] - 1;
        end else if (!req_out[i] && en_in[i]) begin
          req_out[i] <= 1'b1;
        end
      end
    end
  end
  // Data frozen while requesting, changes every cycle otherwise
  always_ff @(negedge clk_in) begin
    for (int i = 0; i < IOC_N_CHAN; i++) begin
      if (!req_out[i]) data_out[i] <= rnd_in ^ IOC_WORD_W'(i);
    end
  end
endmodule : ioc_periph
`default_nettype wire

// *** bench/tb_io_channel_block_transfer.sv ***
// Self-checking bench for the I/O channel block-transfer section
`timescale 1ns/1ps
`default_nettype none
module tb_io_channel_block_transfer import ioc_pkg::*;;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  wire logic [27:0] req;
  wire logic [27:0] ack;
  wire logic [13:0][29:0] in_data;
  logic [2:0][29:0] gen_drv;
  logic [29:0] peer_o, rnd, wdata, rdata;
  logic [13:0] act_in, act_out, done_in, done_out;
  logic s_valid, s_dir, busy, p_valid, p_we, ready, slow;
  logic [3:0] s_chan;
  logic [14:0] p_addr;
  logic [27:0] en, actm;
  logic [29:0] mem [32768];
  int seed = 32'hb254;
  int fails = 0, compares = 0, cyc = 0, tlast = 0, gmax = 0;
  int ord [$];
  always #10 clk = ~clk;
  always @(posedge clk) cyc++;
  always @(negedge clk) rnd <= 30'($random(seed));
  ioc_chan_top dut_u (.sys_clk_in(clk), .rst_n_in(rst_n), .in_req_in(req[13:0]),
    .in_data_in(in_data), .in_ack_out(ack[13:0]), .out_req_in(req[27:14]),
    .out_ack_out(ack[27:14]), .gen_drv_out(gen_drv), .peer_out_out(peer_o),
    .start_valid_in(s_valid), .start_dir_in(s_dir), .start_chan_in(s_chan),
    .start_busy_out(busy), .act_in_out(act_in), .act_out_out(act_out),
    .done_in_out(done_in), .done_out_out(done_out), .prog_valid_in(p_valid),
    .prog_we_in(p_we), .prog_addr_in(p_addr), .prog_wdata_in(wdata),
    .prog_ready_out(ready), .prog_rdata_out(rdata));
  ioc_periph peer_u (.clk_in(clk), .rst_n_in(rst_n), .slow_in(slow), .rnd_in(rnd),
    .en_in(en), .ack_in(ack), .req_out(req), .data_out(in_data));
  // ==========
  // Checking and bus tasks
  task automatic check(string nm, logic [29:0] seen, logic [29:0] exp);
    compares++;
    if (seen !== exp || $isunknown(seen)) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic print_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict
  task automatic prog(logic we, logic [14:0] a, logic [29:0] d);
    int n;
    n = 0;
    // Always let one edge pass so the strobe is seen low between two accesses
    do begin
      @(negedge clk);
      n++;
    end while (ready !== 1'b1 && n < 2000);
    if (n >= 2000) fails++;
    p_valid = 1'b1;
    p_we = we;
    p_addr = a;
    wdata = d;
    @(negedge clk);
    p_valid = 1'b0;
    if (we) mem[a] = d;
    else check("storage", rdata, mem[a]);
  endtask : prog
  task automatic blk(logic we, logic [14:0] a, int n);
    for (int k = 0; k < n; k++) prog(we, a + 15'(k), 30'($random(seed)));
  endtask : blk
  task automatic cw(logic dir, int ch, logic [14:0] up, logic [14:0] lo);
    prog(1'b1, (dir ? IOC_CW_OUT_BASE : IOC_CW_IN_BASE) + 15'(ch), {up, lo});
  endtask : cw
  task automatic start(logic dir, logic [3:0] ch);
    logic exp;
    @(negedge clk);
    exp = ch >= 14 || actm[ch + 14 * dir];
    s_valid = 1'b1;
    s_dir = dir;
    s_chan = ch;
    #1 check("busy", 30'(busy), 30'(exp));
    @(negedge clk);
    s_valid = 1'b0;
    if (!exp) actm[ch + 14 * dir] = 1'b1;
    check("act", 30'({act_out, act_in}), 30'(actm));
  endtask : start
  task automatic wait_idle();
    int n;
    n = 0;
    while ({act_out, act_in} !== '0 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    if (n == 20000) fails++;
    // The monitor logs the final acknowledge on the edge that clears the channel
    @(negedge clk);
  endtask : wait_idle
  task automatic ordchk(int e[$]);
    check("acks", 30'(ord.size()), 30'(e.size()));
    foreach (e[k]) check("order", 30'(ord[k]), 30'(e[k]));
    ord.delete();
  endtask : ordchk
  // ==========
  // Model: every acknowledge applies one control-word step
  always @(negedge clk) begin : mon
    logic [14:0] a;
    logic [14:0] up;
    logic dn;
    for (int i = 0; i < 28; i++) begin
      if (rst_n && ack[i] === 1'b1) begin
        a = (i < 14 ? IOC_CW_IN_BASE : IOC_CW_OUT_BASE) + 15'(i % 14);
        up = mem[a][29:15];
        if (i < 14) mem[up] = in_data[i];
        else if (i < 16) check("peer", peer_o, mem[up]);
        else for (int g = 0; g < 3; g++) check("drv", gen_drv[g], mem[up]);
        dn = (up + 15'h0001) == mem[a][14:0];
        mem[a] = {up + 15'h0001, mem[a][14:0]};
        check("done", 30'(i < 14 ? done_in[i] : done_out[i-14]), 30'(dn));
        if (dn) actm[i] = 1'b0;
        check("act", 30'({act_out, act_in}), 30'(actm));
        if (tlast > 0 && cyc - tlast > gmax) gmax = cyc - tlast;
        tlast = cyc;
        ord.push_back(i);
      end
    end
  end
  initial begin
    #1200000;
    fails++;
    print_verdict();
  end
  initial begin
    {en, actm, s_valid, s_dir, s_chan, p_valid, p_we, p_addr, wdata} = '0;
    slow = 1'b1;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    check("ready", 30'(ready), 30'h1);
    // Storage is not cleared: give every control word a known value first
    blk(1'b1, IOC_CW_IN_BASE, 32);
    // Top and bottom of storage must not alias
    blk(1'b1, 15'h7ffe, 2);
    blk(1'b1, 15'h0000, 2);
    blk(1'b0, 15'h7ffe, 2);
    blk(1'b0, 15'h0000, 2);
    cw(1'b0, 9, 15'h0100, 15'h0102);
    cw(1'b0, 5, 15'h0200, 15'h0202);
    cw(1'b0, 1, 15'h0300, 15'h0301);
    foreach (actm[i]) if (i == 9 || i == 5 || i == 1) start(1'b0, 4'(i));
    start(1'b0, 4'h9);
    start(1'b1, 4'hf);
    en = 28'h0000222;
    wait_idle();
    ordchk('{9, 5, 9, 5, 1});
    blk(1'b0, 15'h0100, 2);
    blk(1'b0, 15'h0200, 2);
    blk(1'b0, 15'h0300, 1);
    blk(1'b0, IOC_CW_IN_BASE, 14);
    // Output mix: the input request wins, then outputs by number
    blk(1'b1, 15'h0400, 1);
    blk(1'b1, 15'h0410, 2);
    blk(1'b1, 15'h0420, 1);
    cw(1'b1, 13, 15'h0400, 15'h0401);
    cw(1'b1, 3, 15'h0410, 15'h0412);
    cw(1'b1, 1, 15'h0420, 15'h0421);
    cw(1'b0, 2, 15'h0500, 15'h0501);
    start(1'b1, 4'hd);
    start(1'b1, 4'h3);
    start(1'b1, 4'h1);
    start(1'b0, 4'h2);
    en = en | 28'h8028004;
    wait_idle();
    ordchk('{2, 27, 17, 15, 17});
    blk(1'b0, 15'h0500, 1);
    blk(1'b0, IOC_CW_OUT_BASE, 14);
    // Prompt peripheral: per-channel rate bound of 1666 cycles a word
    slow = 1'b0;
    blk(1'b1, 15'h0600, 3);
    cw(1'b1, 7, 15'h0600, 15'h0603);
    start(1'b1, 4'h7);
    tlast = 0;
    gmax = 0;
    en = en | 28'h0200000;
    wait_idle();
    ordchk('{21, 21, 21});
    check("rate", 30'(gmax <= 1666 && gmax > 0), 30'h1);
    print_verdict();
  end
endmodule : tb_io_channel_block_transfer
`default_nettype wire
